// file: design/hb_cfg_pkg.sv
// Shared constants, field layouts and carriers for the half-bridge timing configuration slice
package hb_cfg_pkg;

  // Clock and derived time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int NUM_CHAN      = 4;
  localparam int CNT_W         = 10;

  // Register addresses, taken from the frame address bits A3..A0
  localparam logic [3:0] ADDR_PWM_SOURCE_SELECT = 4'h3;
  localparam logic [3:0] ADDR_CALIBRATION_CTRL  = 4'h4;
  localparam logic [3:0] ADDR_CHAN_CONFIG_A0    = 4'h5;
  localparam logic [3:0] ADDR_CHAN_CONFIG_A3    = 4'h8;

  // Source select bit positions, one per channel, every second bit
  localparam int PWM_SEL_POS0 = 0;
  localparam int PWM_SEL_STEP = 2;

  // Calibration word layout
  localparam int CAL_DLY_MSB = 10;
  localparam int CAL_DLY_LSB = 7;
  localparam int CAL_PC_MSB  = 6;
  localparam int CAL_PC_LSB  = 3;
  localparam int CAL_SEL_MSB = 2;
  localparam int CAL_SEL_LSB = 0;
  localparam logic [2:0] CAL_SEL_FIRST = 3'h1;
  localparam logic [2:0] CAL_SEL_LAST  = 3'h4;

  // Configuration-A word layout; bit 10 set marks configuration B
  localparam int CFG_B_MARK_POS = 10;
  localparam int BLANK_MSB      = 9;
  localparam int BLANK_LSB      = 8;
  localparam int FALL_I_MSB     = 7;
  localparam int FALL_I_LSB     = 5;
  localparam int RISE_I_MSB     = 4;
  localparam int RISE_I_LSB     = 2;
  localparam int PC_DUR_MSB     = 1;
  localparam int PC_DUR_LSB     = 0;

  // Reset values
  localparam logic [3:0] PWM_SEL_RESET = 4'h0;
  localparam logic [2:0] CAL_SEL_RESET = 3'h0;
  localparam logic [3:0] CAL_DLY_RESET = 4'h0;
  localparam logic [3:0] CAL_PC_RESET  = 4'h0;
  localparam logic [1:0] BLANK_RESET   = 2'h0;
  localparam logic [2:0] FALL_I_RESET  = 3'h0;
  localparam logic [2:0] RISE_I_RESET  = 3'h0;
  localparam logic [1:0] PC_DUR_RESET  = 2'h0;

  // Times in ns: base at code zero and step per code
  localparam int CAL_DLY_BASE_NS = 350;
  localparam int CAL_DLY_STEP_NS = 200;
  localparam int CAL_PC_BASE_NS  = 50;
  localparam int CAL_PC_STEP_NS  = 100;
  localparam int BLANK_BASE_NS   = 1000;
  localparam int BLANK_STEP_NS   = 1000;
  localparam int PC_DUR_BASE_NS  = 100;
  localparam int PC_DUR_STEP_NS  = 100;

  // Least times, so cycle counts round up
  localparam int CAL_DLY_BASE_CYC = (CAL_DLY_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_DLY_STEP_CYC = (CAL_DLY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_PC_BASE_CYC  = (CAL_PC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_PC_STEP_CYC  = (CAL_PC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_BASE_CYC   = (BLANK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_STEP_CYC   = (BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_DUR_BASE_CYC  = (PC_DUR_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_DUR_STEP_CYC  = (PC_DUR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Decoded register write from the serial frame logic
  typedef struct packed {
    logic [3:0]  addr;
    logic [10:0] data;
  } reg_wr_t;

  // Per-channel configuration-A fields
  typedef struct packed {
    logic [1:0] cross_conduction_blank;
    logic [2:0] fall_precharge_current;
    logic [2:0] rise_precharge_current;
    logic [1:0] precharge_duration;
  } chan_cfg_t;

  // Per-channel settings handed to the gate-drive stage
  typedef struct packed {
    chan_cfg_t        codes;
    logic [CNT_W-1:0] blank_cycles;
    logic [CNT_W-1:0] precharge_cycles;
    logic             pwm_drive;
  } chan_out_t;

  // Calibration settings handed to the calibration unit
  typedef struct packed {
    logic             enable;
    logic [3:0]       channel_onehot;
    logic [CNT_W-1:0] slope_end_delay_cycles;
    logic [CNT_W-1:0] precharge_cycles;
  } cal_out_t;

endpackage

// file: design/half_bridge_channel_cfg.sv
// One half-bridge channel: configuration-A register, timing decode and PWM source mux
`timescale 1ns/1ps
module half_bridge_channel_cfg
  import hb_cfg_pkg::*;
#(
  parameter logic [3:0] CHAN_ADDR = ADDR_CHAN_CONFIG_A0
) (
  input  wire logic      mclk,
  input  wire logic      rstn,
  input  wire logic      wr_valid,
  input  wire reg_wr_t   wr,
  input  wire logic      pwm_source_sel,
  input  wire logic      pwm_a_sync,
  input  wire logic      pwm_b_sync,
  output logic           cfg_hit,
  output chan_out_t      chan_out
);

  chan_cfg_t        cfg_q;
  chan_cfg_t        codes_q;
  logic [CNT_W-1:0] blank_cyc_q;
  logic [CNT_W-1:0] pc_cyc_q;
  logic             pwm_drive_q;
  logic             hit;

  // Bit 10 set addresses configuration B, which lives in another block
  assign hit = wr_valid && (wr.addr == CHAN_ADDR) && !wr.data[CFG_B_MARK_POS];
  assign cfg_hit = hit;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cfg_q <= '{BLANK_RESET, FALL_I_RESET, RISE_I_RESET, PC_DUR_RESET};
    end else if (hit) begin
      cfg_q.cross_conduction_blank <= wr.data[BLANK_MSB:BLANK_LSB];
      cfg_q.fall_precharge_current <= wr.data[FALL_I_MSB:FALL_I_LSB];
      cfg_q.rise_precharge_current <= wr.data[RISE_I_MSB:RISE_I_LSB];
      cfg_q.precharge_duration     <= wr.data[PC_DUR_MSB:PC_DUR_LSB];
    end
  end

  // Codes are decoded from the stored word so outputs follow one cycle later
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      codes_q     <= '{BLANK_RESET, FALL_I_RESET, RISE_I_RESET, PC_DUR_RESET};
      blank_cyc_q <= CNT_W'(BLANK_BASE_CYC);
      pc_cyc_q    <= CNT_W'(PC_DUR_BASE_CYC);
    end else begin
      codes_q     <= cfg_q;
      blank_cyc_q <= CNT_W'(BLANK_BASE_CYC + BLANK_STEP_CYC * int'(cfg_q.cross_conduction_blank));
      pc_cyc_q    <= CNT_W'(PC_DUR_BASE_CYC + PC_DUR_STEP_CYC * int'(cfg_q.precharge_duration));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwm_drive_q <= 1'b0;
    end else begin
      pwm_drive_q <= pwm_source_sel ? pwm_b_sync : pwm_a_sync;
    end
  end

  // One driver for the whole carrier; every field comes from a flop
  assign chan_out = '{codes: codes_q, blank_cycles: blank_cyc_q, precharge_cycles: pc_cyc_q, pwm_drive: pwm_drive_q};

endmodule

// file: design/half_bridge_timing_config_regs.sv
// Register slice for PWM source select, calibration control and per-channel configuration A
`timescale 1ns/1ps
module half_bridge_timing_config_regs
  import hb_cfg_pkg::*;
#(
  parameter int NCHAN = NUM_CHAN
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 wr_valid,
  input  wire reg_wr_t              wr,
  input  wire logic                 pwm_input_a,
  input  wire logic                 pwm_input_b,
  input  wire logic [NCHAN-1:0]     channel_output_enable,
  output logic                      wr_taken,
  output logic                      wr_while_enabled,
  output logic [NCHAN-1:0]          pwm_source_sel,
  output cal_out_t                  cal_out,
  output chan_out_t [NCHAN-1:0]     chan_out
);

  // Widest code of each field, from its bit span
  localparam int BLANK_CODE_MAX   = (1 << (BLANK_MSB - BLANK_LSB + 1)) - 1;
  localparam int PC_DUR_CODE_MAX  = (1 << (PC_DUR_MSB - PC_DUR_LSB + 1)) - 1;
  localparam int CAL_DLY_CODE_MAX = (1 << (CAL_DLY_MSB - CAL_DLY_LSB + 1)) - 1;
  localparam int CAL_PC_CODE_MAX  = (1 << (CAL_PC_MSB - CAL_PC_LSB + 1)) - 1;

  // Largest decoded counts; each must fit the count outputs
  localparam int BLANK_MAX_CYC    = BLANK_BASE_CYC + BLANK_STEP_CYC * BLANK_CODE_MAX;
  localparam int PC_DUR_MAX_CYC   = PC_DUR_BASE_CYC + PC_DUR_STEP_CYC * PC_DUR_CODE_MAX;
  localparam int CAL_DLY_MAX_CYC  = CAL_DLY_BASE_CYC + CAL_DLY_STEP_CYC * CAL_DLY_CODE_MAX;
  localparam int CAL_PC_MAX_CYC   = CAL_PC_BASE_CYC + CAL_PC_STEP_CYC * CAL_PC_CODE_MAX;
  localparam int CNT_LIMIT        = 1 << CNT_W;
  localparam int SEL_TOP_POS      = PWM_SEL_POS0 + PWM_SEL_STEP * (NCHAN - 1);
  localparam int DATA_W           = $bits(wr.data);

  // Elaboration checks: the logic below serves the four-channel layout only
  if (NCHAN != NUM_CHAN) begin : g_bad_nchan
    $error("half_bridge_timing_config_regs: channel count must be 4");
  end

  if (SEL_TOP_POS >= DATA_W) begin : g_bad_sel_pos
    $error("half_bridge_timing_config_regs: source select bits exceed the data word");
  end

  if (int'(ADDR_CHAN_CONFIG_A0) + NCHAN - 1 != int'(ADDR_CHAN_CONFIG_A3)) begin : g_bad_addr
    $error("half_bridge_timing_config_regs: configuration-A addresses must be consecutive");
  end

  if (int'(CAL_SEL_LAST) - int'(CAL_SEL_FIRST) + 1 != NCHAN) begin : g_bad_cal_sel
    $error("half_bridge_timing_config_regs: calibration select must cover every channel");
  end

  // Counts too wide for the outputs would wrap silently in the drive stages
  if (BLANK_MAX_CYC >= CNT_LIMIT || PC_DUR_MAX_CYC >= CNT_LIMIT) begin : g_bad_chan_cnt
    $error("half_bridge_timing_config_regs: channel counts exceed the count width");
  end

  if (CAL_DLY_MAX_CYC >= CNT_LIMIT || CAL_PC_MAX_CYC >= CNT_LIMIT) begin : g_bad_cal_cnt
    $error("half_bridge_timing_config_regs: calibration counts exceed the count width");
  end

  // Two-stage synchronisers for the asynchronous PWM pins
  logic [1:0] pwm_a_sync_q;
  logic [1:0] pwm_b_sync_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwm_a_sync_q <= 2'h0;
    end else begin
      pwm_a_sync_q <= {pwm_a_sync_q[0], pwm_input_a};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwm_b_sync_q <= 2'h0;
    end else begin
      pwm_b_sync_q <= {pwm_b_sync_q[0], pwm_input_b};
    end
  end

  logic hit_pwm_sel;
  logic hit_cal;
  logic [NCHAN-1:0] hit_chan;
  logic [NCHAN-1:0] chan_hit_enabled;

  assign hit_pwm_sel = wr_valid && (wr.addr == ADDR_PWM_SOURCE_SELECT);
  assign hit_cal     = wr_valid && (wr.addr == ADDR_CALIBRATION_CTRL);

  logic [NCHAN-1:0] pwm_sel_d;

  always_comb begin
    pwm_sel_d = pwm_source_sel;
    if (hit_pwm_sel) begin
      for (int i = 0; i < NCHAN; i++) begin
        pwm_sel_d[i] = wr.data[PWM_SEL_POS0 + PWM_SEL_STEP * i];
      end
    end
  end

  // Odd data bits of this word are ignored
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwm_source_sel <= NCHAN'(PWM_SEL_RESET);
    end else begin
      pwm_source_sel <= pwm_sel_d;
    end
  end

  logic [3:0] cal_dly_q;
  logic [3:0] cal_pc_q;
  logic [2:0] cal_sel_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cal_dly_q <= CAL_DLY_RESET;
      cal_pc_q  <= CAL_PC_RESET;
      cal_sel_q <= CAL_SEL_RESET;
    end else if (hit_cal) begin
      cal_dly_q <= wr.data[CAL_DLY_MSB:CAL_DLY_LSB];
      cal_pc_q  <= wr.data[CAL_PC_MSB:CAL_PC_LSB];
      cal_sel_q <= wr.data[CAL_SEL_MSB:CAL_SEL_LSB];
    end
  end

  logic       cal_sel_valid;
  logic [3:0] cal_onehot;

  always_comb begin
    cal_sel_valid = (cal_sel_q >= CAL_SEL_FIRST) && (cal_sel_q <= CAL_SEL_LAST);
    cal_onehot    = 4'h0;
    if (cal_sel_valid) begin
      cal_onehot[2'(cal_sel_q - CAL_SEL_FIRST)] = 1'b1;
    end
  end

  cal_out_t cal_d;

  always_comb begin
    cal_d.enable                 = cal_sel_valid;
    cal_d.channel_onehot         = cal_onehot;
    cal_d.slope_end_delay_cycles = CNT_W'(CAL_DLY_BASE_CYC + CAL_DLY_STEP_CYC * int'(cal_dly_q));
    cal_d.precharge_cycles       = CNT_W'(CAL_PC_BASE_CYC + CAL_PC_STEP_CYC * int'(cal_pc_q));
  end

  // Registered so the calibration unit never sees a half-decoded word
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cal_out.enable                 <= 1'b0;
      cal_out.channel_onehot         <= 4'h0;
      cal_out.slope_end_delay_cycles <= CNT_W'(CAL_DLY_BASE_CYC);
      cal_out.precharge_cycles       <= CNT_W'(CAL_PC_BASE_CYC);
    end else begin
      cal_out <= cal_d;
    end
  end

  // One configuration-A register per channel at consecutive addresses
  for (genvar c = 0; c < NCHAN; c++) begin : g_chan
    half_bridge_channel_cfg #(
      .CHAN_ADDR (4'(ADDR_CHAN_CONFIG_A0 + c))
    ) u_chan (
      .mclk           (mclk),
      .rstn           (rstn),
      .wr_valid       (wr_valid),
      .wr             (wr),
      .pwm_source_sel (pwm_source_sel[c]),
      .pwm_a_sync     (pwm_a_sync_q[1]),
      .pwm_b_sync     (pwm_b_sync_q[1]),
      .cfg_hit        (hit_chan[c]),
      .chan_out       (chan_out[c])
    );
  end

  // flag writes to an enabled channel
  // The write is still applied: the host owns this rule, the flag only makes misuse visible
  assign chan_hit_enabled = hit_chan & channel_output_enable;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_while_enabled <= 1'b0;
    end else begin
      wr_while_enabled <= |chan_hit_enabled;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_taken <= 1'b0;
    end else begin
      wr_taken <= hit_pwm_sel || hit_cal || (|hit_chan);
    end
  end

endmodule

// file: verification/hb_host.sv
// Host model that issues register writes to the slice
`timescale 1ns/1ps
module hb_host
  import hb_cfg_pkg::*;
(
  input  wire logic mclk,
  output logic       wr_valid,
  output reg_wr_t    wr,
  output logic [3:0] channel_output_enable
);
  initial begin
    wr_valid = 1'b0;
    wr = '0;
    channel_output_enable = 4'h0;
  end
  task automatic put(input logic [3:0] a, input logic [10:0] d, input bit rude);
    @(negedge mclk);
    if (a >= 4'h5 && a <= 4'h8 && !rude) channel_output_enable[2'(a - 4'h5)] = 1'b0;
    wr_valid = 1'b1;
    wr = '{addr: a, data: d};
  endtask
  // Released bus shows the inverse so stale data cannot pass
  task automatic idle();
    @(negedge mclk);
    wr_valid = 1'b0;
    wr = ~wr;
  endtask
  task automatic ena(input logic [3:0] m);
    channel_output_enable = m;
  endtask
endmodule

// file: verification/hb_regs_chk.sv
// Port assertions for the register slice
`timescale 1ns/1ps
module hb_regs_chk
  import hb_cfg_pkg::*;
#(
  parameter int NCHAN = 4
) (
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic             wr_valid,
  input wire reg_wr_t          wr,
  input wire logic             pwm_input_a,
  input wire logic             pwm_input_b,
  input wire logic [NCHAN-1:0] channel_output_enable,
  input wire logic             wr_taken,
  input wire logic             wr_while_enabled,
  input wire logic [NCHAN-1:0] pwm_source_sel,
  input wire cal_out_t         cal_out,
  input wire chan_out_t [NCHAN-1:0] chan_out
);
  logic       cfg_w, hit_w;
  logic [1:0] ch_w;
  logic [3:0] oh_w;
  assign cfg_w = wr_valid && wr.addr >= 4'h5 && wr.addr <= 4'h8 && !wr.data[10];
  assign hit_w = cfg_w || (wr_valid && wr.addr inside {4'h3, 4'h4});
  assign ch_w = 2'(wr.addr - 4'h5);
  assign oh_w = (wr.data[2:0] inside {[3'h1:3'h4]}) ? 4'h1 << (wr.data[2:0] - 3'h1) : 4'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  taken_pulse_a: assert property (hit_w |=> wr_taken) else $error("write not taken");
  refused_write_a: assert property (!hit_w |=> !wr_taken) else $error("write wrongly taken");
  sel_map_a: assert property (wr_valid && wr.addr == 4'h3 |=>
    pwm_source_sel == $past({wr.data[6], wr.data[4], wr.data[2], wr.data[0]})) else $error("source select");
  cal_sel_a: assert property (wr_valid && wr.addr == 4'h4 |-> ##2
    cal_out.channel_onehot == $past(oh_w, 2) && cal_out.enable == |$past(oh_w, 2)) else $error("cal select");
  cal_time_a: assert property (wr_valid && wr.addr == 4'h4 |-> ##2
    cal_out.slope_end_delay_cycles == 10'(35 + 20 * $past(wr.data[10:7], 2))
    && cal_out.precharge_cycles == 10'(5 + 10 * $past(wr.data[6:3], 2))) else $error("cal times");
  cfg_codes_a: assert property (cfg_w |-> ##2
    chan_out[$past(ch_w, 2)].codes == $past(wr.data[9:0], 2)) else $error("config codes");
  cfg_time_a: assert property (cfg_w |-> ##2
    chan_out[$past(ch_w, 2)].blank_cycles == 10'(100 * ($past(wr.data[9:8], 2) + 1))
    && chan_out[$past(ch_w, 2)].precharge_cycles == 10'(10 * ($past(wr.data[1:0], 2) + 1)))
    else $error("config times");
  misuse_flag_a: assert property (wr_while_enabled == $past(cfg_w && channel_output_enable[ch_w]))
    else $error("misuse flag");
  for (genvar i = 0; i < NCHAN; i++) begin : g_pwm
    pwm_route_a: assert property ($past(rstn, 3) |-> chan_out[i].pwm_drive ==
      ($past(pwm_source_sel[i]) ? $past(pwm_input_b, 3) : $past(pwm_input_a, 3))) else $error("pwm route");
  end
  cover property (wr_valid && wr.addr == 4'h4);
  cover property (cfg_w);
  cover property (wr_while_enabled);
endmodule
bind half_bridge_timing_config_regs hb_regs_chk #(.NCHAN(NCHAN)) u_chk (.mclk(mclk), .rstn(rstn),
  .wr_valid(wr_valid), .wr(wr), .pwm_input_a(pwm_input_a), .pwm_input_b(pwm_input_b),
  .channel_output_enable(channel_output_enable), .wr_taken(wr_taken), .wr_while_enabled(wr_while_enabled),
  .pwm_source_sel(pwm_source_sel), .cal_out(cal_out), .chan_out(chan_out));

// file: verification/tb_top.sv
// Self-checking bench for the half-bridge timing configuration slice
`timescale 1ns/1ps
module tb_top
  import hb_cfg_pkg::*;
;
  typedef struct packed {
    logic            w;
    logic [3:0]      s;
    cal_out_t        c;
    chan_out_t [3:0] h;
  } note_t;
  logic            mclk, rstn, wr_valid, pwm_input_a, pwm_input_b, wr_taken, wr_while_enabled, pend;
  reg_wr_t         wr;
  logic [3:0]      channel_output_enable, pwm_source_sel;
  cal_out_t        cal_out;
  chan_out_t [3:0] chan_out;
  note_t           e, p, q[$];
  int              failures, n_tests, k, j;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  half_bridge_timing_config_regs u_dut (.mclk(mclk), .rstn(rstn), .wr_valid(wr_valid), .wr(wr),
    .pwm_input_a(pwm_input_a), .pwm_input_b(pwm_input_b), .channel_output_enable(channel_output_enable),
    .wr_taken(wr_taken), .wr_while_enabled(wr_while_enabled), .pwm_source_sel(pwm_source_sel),
    .cal_out(cal_out), .chan_out(chan_out));
  hb_host u_host (.mclk(mclk), .wr_valid(wr_valid), .wr(wr), .channel_output_enable(channel_output_enable));
  task automatic cmp(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t output differs from expected", $time);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic put(input logic [3:0] a, input logic [10:0] d, input bit rude);
    int c;
    c = int'(a) - 5;
    u_host.put(a, d, rude);
    if (a == 4'h3) e.s = {d[6], d[4], d[2], d[0]};
    if (a == 4'h4) begin
      e.c.enable = d[2:0] inside {[1:4]};
      e.c.channel_onehot = e.c.enable ? 4'h1 << (d[2:0] - 1) : 4'h0;
      e.c.slope_end_delay_cycles = 10'((350 + 200 * d[10:7]) / 10);
      e.c.precharge_cycles = 10'((50 + 100 * d[6:3]) / 10);
    end
    e.w = 1'b0;
    if (c >= 0 && c < 4 && !d[10]) begin
      e.h[c].codes = d[9:0];
      e.h[c].blank_cycles = 10'(1000 * (d[9:8] + 1) / 10);
      e.h[c].precharge_cycles = 10'(100 * (d[1:0] + 1) / 10);
      e.w = channel_output_enable[c];
    end
    if (a inside {[4'h3:4'h8]} && !(c >= 0 && d[10])) q.push_back(e);
  endtask
  // Settings land one cycle after the select and flag
  always @(negedge mclk) begin
    if (pend) begin
      for (int i = 0; i < 4; i++) p.h[i].pwm_drive = chan_out[i].pwm_drive;
      cmp({cal_out, chan_out} === {p.c, p.h});
      pend = 1'b0;
    end
    if (wr_taken === 1'b1) begin
      if (q.size() == 0) cmp(1'b0);
      else begin
        p = q.pop_front();
        pend = 1'b1;
        cmp({wr_while_enabled, pwm_source_sel} === {p.w, p.s});
      end
    end
  end
  initial begin
    failures = 0;
    n_tests = 0;
    pend = 1'b0;
    rstn = 1'b0;
    pwm_input_a = 1'b0;
    pwm_input_b = 1'b0;
    k = $urandom(48);
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    e = '0;
    e.c.slope_end_delay_cycles = 10'(350 / 10);
    e.c.precharge_cycles = 10'(50 / 10);
    for (k = 0; k < 4; k++) e.h[k].blank_cycles = 10'(1000 / 10);
    for (k = 0; k < 4; k++) e.h[k].precharge_cycles = 10'(100 / 10);
    cmp({pwm_source_sel, cal_out, chan_out} === {e.s, e.c, e.h});
    for (k = 0; k < 8; k++) put(4'h4, {4'($urandom), 4'($urandom), 3'(k)}, 1'b0);
    put(4'h4, 11'h7fc, 1'b0);
    repeat (4) put(4'h3, 11'($urandom), 1'b0);
    // duration climbs one code per round
    for (k = 0; k < 16; k++) put(4'(5 + k % 4), {1'b0, 8'($urandom), 2'(k / 4)}, 1'b0);
    for (k = 9; k < 19; k++) put(4'(k), 11'($urandom), 1'b0);
    for (k = 0; k < 4; k++) put(4'(5 + k), {1'b1, 10'($urandom)}, 1'b0);
    u_host.idle();
    u_host.ena(4'hf);
    put(4'h7, {1'b0, 8'($urandom), 2'h3}, 1'b1);
    put(4'h8, {1'b0, 8'($urandom), 2'h3}, 1'b0);
    for (k = 0; k < 4; k++) begin
      put(4'h3, 11'($urandom), 1'b0);
      u_host.idle();
      pwm_input_a = 1'($urandom);
      pwm_input_b = ~pwm_input_a;
      repeat (4) @(negedge mclk);
      for (j = 0; j < 4; j++) cmp(chan_out[j].pwm_drive === (e.s[j] ? pwm_input_b : pwm_input_a));
    end
    repeat (3) @(negedge mclk);
    cmp(q.size() == 0);
    close_out();
  end
endmodule
